// file: hdl/bpf_pat_if.sv
`timescale 1ns/1ps
// ==========================================================
// Pattern store port between the sequencer and its memory.
// ==========================================================
interface bpf_pat_if;
    logic       we;    // Write one fetched pattern byte.
    logic [5:0] waddr; // Byte index being filled.
    logic [7:0] wdata; // Byte from the frame buffer.
    logic [5:0] raddr; // Byte index wanted for the next pixel.
    logic [7:0] rdata; // Registered read data, one cycle later.

    modport eng (output we, output waddr, output wdata, output raddr,
                 input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface

// file: hdl/bpf_pat_ram.sv
`timescale 1ns/1ps
// ==========================================================
// 8x8 pattern store, 64 bytes, registered read.
// ==========================================================
module bpf_pat_ram (
    input wire logic pclk,
    bpf_pat_if.mem   port
);
    logic [7:0] mem_q [64];  // Pattern bytes, no reset needed.
    logic [7:0] rdata_q;     // Read register.

    // Write the fetched byte and register the read each cycle.
    always_ff @(posedge pclk) begin
        if (port.we) begin
            mem_q[port.waddr] <= port.wdata;
        end
        rdata_q <= mem_q[port.raddr];
    end

    assign port.rdata = rdata_q;
endmodule

// file: hdl/bpf_pkg.sv
package bpf_pkg;

    // ==========================================================
    // Register byte offsets on the APB bus.
    // ==========================================================
    localparam logic [7:0] OFF_DEST_PITCH = 8'h00; // Line pitches.
    localparam logic [7:0] OFF_EXP_BG     = 8'h04; // Expansion background.
    localparam logic [7:0] OFF_EXP_FG     = 8'h08; // Expansion foreground.
    localparam logic [7:0] OFF_MONO_SRC   = 8'h0c; // One-bit source control.
    localparam logic [7:0] OFF_CONTROL    = 8'h10; // Operation control.
    localparam logic [7:0] OFF_PAT_BASE   = 8'h14; // Pattern base.
    localparam logic [7:0] OFF_SRC_BASE   = 8'h18; // Source base.
    localparam logic [7:0] OFF_DEST_BASE  = 8'h1c; // Destination base.
    localparam logic [7:0] OFF_EXTENT     = 8'h20; // Height and width.
    localparam logic [7:0] OFF_CONFIG     = 8'h80; // Depth and busy.

    // ==========================================================
    // Field positions.
    // ==========================================================
    localparam int DPITCH_MSB  = 28; // Destination line pitch.
    localparam int DPITCH_LSB  = 16;
    localparam int CTL_BUSY    = 31; // Busy copy in the control register.
    localparam int CTL_ROW_MSB = 22; // Starting pattern row.
    localparam int CTL_ROW_LSB = 20;
    localparam int CTL_SOLID   = 19; // Set: solid foreground, no fetch.
    localparam int CTL_MONO_PAT = 18; // Set: one-bit pattern.
    localparam int CTL_MASK_MSB = 16; // Per-pixel write masking.
    localparam int CTL_MASK_LSB = 13;
    localparam int ROP_MSB     = 7;  // Raster operation code.
    localparam int PBASE_MSB   = 22; // Pattern base, quadword aligned.
    localparam int PBASE_LSB   = 3;
    localparam int DBASE_MSB   = 22; // Destination base byte offset.
    localparam int EXT_H_MSB   = 28; // Height in lines.
    localparam int EXT_H_LSB   = 16;
    localparam int EXT_W_MSB   = 12; // Width in bytes.
    localparam int CFG_BUSY    = 0;  // Busy bit in the config register.

    // ==========================================================
    // Reset values and fixed sizes.
    // ==========================================================
    localparam logic [31:0] REG_RESET  = 32'h0000_0000;
    localparam logic [7:0]  CFG_RESET  = 8'h00; // 8 bpp, normal operation.
    localparam logic [6:0]  PAT_COLOUR_LAST = 7'h3f; // 64 pattern bytes.
    localparam logic [6:0]  PAT_MONO_LAST   = 7'h07; // 8 pattern bytes.

    // Engine sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_PREQ  = 3'b001,
        ST_PWAIT = 3'b010,
        ST_PIX   = 3'b011,
        ST_CALC  = 3'b100,
        ST_DRD   = 3'b101,
        ST_DWR   = 3'b110,
        ST_DONE  = 3'b111
    } bpf_state_e;

endpackage

// file: hdl/bpf_rop.sv
`timescale 1ns/1ps
// ==========================================================
// Bitwise three-operand raster operation on one byte.
// ==========================================================
module bpf_rop (
    input  wire logic [7:0] rop,
    input  wire logic [7:0] pat,
    input  wire logic [7:0] src,
    input  wire logic [7:0] dst,
    output logic      [7:0] res,
    output logic            uses_pat,
    output logic            uses_src,
    output logic            uses_dst
);
    // Each result bit indexes the code by pattern, source and dest.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            res[i] = rop[{pat[i], src[i], dst[i]}];
        end
    end

    // An operand is used when flipping it can change the result.
    assign uses_pat = rop[7:4] != rop[3:0];
    assign uses_src = {rop[7:6], rop[3:2]} != {rop[5:4], rop[1:0]};
    assign uses_dst = {rop[7], rop[5], rop[3], rop[1]}
                   != {rop[6], rop[4], rop[2], rop[0]};
endmodule

// file: hdl/bpf_top.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Destination lives in frame buffer, any pitch.
// - Writes use configured depth; no mono destination. This engine writes every byte at 8 bpp.
// - Destination base bits 22-0 give first byte.
// - Pitch bits 28-16 space destination lines.
// - Source pitch ignored without source operand.
// - Busy reads in config bit 0, control bit 31.
// - Config 00h selects 8 bpp, normal operation.
// - Control bits 22-20 pick first pattern row.
// - Control bit 19 clear uses fetched pattern.
// - Bits 18,17 clear mean colour pattern.
// - Bits 16-13 zero disable write masking.
// - Bit 12 clear leaves source control unused.
// - No source operand: no source fetch or wait.
// - Pattern base bits 22-3 give pattern offset.
// - Extent: height bits 28-16, width 12-0.
// - Non-zero height write starts the operation.
// - Pattern tiles across the whole rectangle.
// - Low three pattern address bits ignored.
// - Mono pattern bit zero expands to foreground.
module bpf_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             fb_req,
    output logic             fb_we,
    output logic      [22:0] fb_addr,
    output logic      [7:0]  fb_wdata,
    input  wire logic        fb_ack,
    input  wire logic [7:0]  fb_rdata,
    output logic             busy
);

    // ==========================================================
    // Register storage.
    // ==========================================================
    logic [31:0] pitch_q;      // Destination and source pitch.
    logic [31:0] exp_bg_q;     // Expansion background colour.
    logic [31:0] exp_fg_q;     // Expansion foreground colour.
    logic [31:0] mono_src_q;   // One-bit source control, stored only.
    logic [31:0] ctrl_q;       // Control, bit 31 is not stored.
    logic [31:0] pat_base_q;   // Pattern base.
    logic [31:0] src_base_q;   // Source base, stored only.
    logic [31:0] dest_base_q;  // Destination base.
    logic [31:0] extent_q;     // Height and width.
    logic [7:0]  config_q;     // Configuration, bit 0 is not stored.
    logic        busy_q;       // Operation in progress.
    logic        pready_q;     // Access phase answer.
    logic        pslverr_q;    // Unmapped address answer.
    logic [31:0] prdata_q;     // Read data for the access phase.

    // ==========================================================
    // Engine state.
    // ==========================================================
    bpf_pkg::bpf_state_e st_q; // Sequencer state.
    logic [6:0]  cnt_q;        // Pattern byte being fetched.
    logic [12:0] x_q;          // Byte within the current line.
    logic [12:0] y_q;          // Current line.
    logic [22:0] line_q;       // Address of the current line start.
    logic [7:0]  pat_q;        // Pattern byte held for a dest read.
    logic        fb_req_q;     // Frame buffer request.
    logic        fb_we_q;      // Request is a write.
    logic [22:0] fb_addr_q;    // Request address.
    logic [7:0]  fb_wdata_q;   // Request write data.

    bpf_pat_if pat_port ();    // Pattern store port.

    // ==========================================================
    // APB decode.
    // ==========================================================
    wire setup    = psel & ~penable & ~pready_q;
    wire wr_fire  = psel & penable & pready_q & pwrite;
    wire hit_pit  = paddr == bpf_pkg::OFF_DEST_PITCH;
    wire hit_bg   = paddr == bpf_pkg::OFF_EXP_BG;
    wire hit_fg   = paddr == bpf_pkg::OFF_EXP_FG;
    wire hit_mono = paddr == bpf_pkg::OFF_MONO_SRC;
    wire hit_ctl  = paddr == bpf_pkg::OFF_CONTROL;
    wire hit_pat  = paddr == bpf_pkg::OFF_PAT_BASE;
    wire hit_src  = paddr == bpf_pkg::OFF_SRC_BASE;
    wire hit_dst  = paddr == bpf_pkg::OFF_DEST_BASE;
    wire hit_ext  = paddr == bpf_pkg::OFF_EXTENT;
    wire hit_cfg  = paddr == bpf_pkg::OFF_CONFIG;
    wire mapped   = hit_pit | hit_bg | hit_fg | hit_mono | hit_ctl
                  | hit_pat | hit_src | hit_dst | hit_ext | hit_cfg;
    // Writes during an operation are dropped so the running setup holds.
    wire wr_ok    = wr_fire & ~busy_q;
    wire [12:0] new_height =
        pwdata[bpf_pkg::EXT_H_MSB:bpf_pkg::EXT_H_LSB];
    wire start    = wr_ok & hit_ext & (new_height != 13'h0000);

    // Busy is visible in two places at once.
    wire [31:0] ctrl_rd = {busy_q, ctrl_q[30:0]};
    wire [31:0] cfg_rd  = {24'h00_0000, config_q[7:1], busy_q};
    wire [31:0] rd_mux  =
        hit_pit  ? pitch_q     :
        hit_bg   ? exp_bg_q    :
        hit_fg   ? exp_fg_q    :
        hit_mono ? mono_src_q  :
        hit_ctl  ? ctrl_rd     :
        hit_pat  ? pat_base_q  :
        hit_src  ? src_base_q  :
        hit_dst  ? dest_base_q :
        hit_ext  ? extent_q    :
        hit_cfg  ? cfg_rd      : 32'h0000_0000;

    // ==========================================================
    // Field views.
    // ==========================================================
    wire [12:0] d_pitch = pitch_q[bpf_pkg::DPITCH_MSB:bpf_pkg::DPITCH_LSB];
    wire [12:0] height  = extent_q[bpf_pkg::EXT_H_MSB:bpf_pkg::EXT_H_LSB];
    wire [12:0] width   = extent_q[bpf_pkg::EXT_W_MSB:0];
    wire [2:0]  row0    = ctrl_q[bpf_pkg::CTL_ROW_MSB:bpf_pkg::CTL_ROW_LSB];
    wire        solid   = ctrl_q[bpf_pkg::CTL_SOLID];
    wire        mono_p  = ctrl_q[bpf_pkg::CTL_MONO_PAT];
    wire [3:0]  mask_m  =
        ctrl_q[bpf_pkg::CTL_MASK_MSB:bpf_pkg::CTL_MASK_LSB];
    wire [7:0]  rop     = ctrl_q[bpf_pkg::ROP_MSB:0];
    // The low three address bits are forced to zero.
    wire [22:0] pat_addr0 =
        {pat_base_q[bpf_pkg::PBASE_MSB:bpf_pkg::PBASE_LSB], 3'b000};
    wire [6:0]  pat_last = mono_p ? bpf_pkg::PAT_MONO_LAST
                                  : bpf_pkg::PAT_COLOUR_LAST;

    // ==========================================================
    // Pattern tiling and expansion.
    // ==========================================================
    // Row wraps every eight lines, column every eight bytes.
    wire [2:0] pat_row = row0 + y_q[2:0];
    wire [2:0] pat_col = x_q[2:0];
    // One-bit patterns keep one byte per row, leftmost pixel in bit 7.
    wire       mono_bit = pat_port.rdata[3'h7 - pat_col];
    // A zero bit takes the foreground colour.
    wire [7:0] mono_pix = mono_bit ? exp_bg_q[7:0] : exp_fg_q[7:0];
    wire [7:0] pat_now  = solid  ? exp_fg_q[7:0] :
                          mono_p ? mono_pix      : pat_port.rdata;
    // Masking only drops background pixels of a one-bit pattern.
    wire       skip_pix = (mask_m != 4'h0) & mono_p & ~solid & mono_bit;

    // ==========================================================
    // Raster operation.
    // ==========================================================
    logic [7:0] rop_res;  // Byte to write.
    logic       uses_pat; // Pattern operand needed.
    logic       uses_src; // Source operand needed.
    logic       uses_dst; // Destination must be read first.
    // No source path exists here, so the source operand is zero and the
    // source pitch and one-bit source control are never consulted.
    wire [7:0] rop_pat = (st_q == bpf_pkg::ST_DRD) ? pat_q : pat_now;
    wire [7:0] rop_dst = (st_q == bpf_pkg::ST_DRD) ? fb_rdata : 8'h00;

    bpf_rop u_rop (
        .rop      (rop),
        .pat      (rop_pat),
        .src      (8'h00),
        .dst      (rop_dst),
        .res      (rop_res),
        .uses_pat (uses_pat),
        .uses_src (),
        .uses_dst (uses_dst)
    );

    // Pattern store fill and lookup.
    assign pat_port.we    = (st_q == bpf_pkg::ST_PWAIT) & fb_ack;
    assign pat_port.waddr = cnt_q[5:0];
    assign pat_port.wdata = fb_rdata;
    assign pat_port.raddr = mono_p ? {3'b000, pat_row} : {pat_row, pat_col};

    bpf_pat_ram u_ram (
        .pclk (pclk),
        .port (pat_port)
    );

    // ==========================================================
    // Loop control.
    // ==========================================================
    wire        last_x   = (x_q + 13'h0001) == width;
    wire        last_y   = (y_q + 13'h0001) == height;
    wire [22:0] pix_addr = line_q + {10'h000, x_q};

    // ==========================================================
    // APB register writes and answers.
    // ==========================================================
    // The answer is registered: setup, then one access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= bpf_pkg::REG_RESET;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q  <= (setup & ~pwrite) ? rd_mux : prdata_q;
        end
    end

    // Software-owned registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pitch_q     <= bpf_pkg::REG_RESET;
            exp_bg_q    <= bpf_pkg::REG_RESET;
            exp_fg_q    <= bpf_pkg::REG_RESET;
            mono_src_q  <= bpf_pkg::REG_RESET;
            ctrl_q      <= bpf_pkg::REG_RESET;
            pat_base_q  <= bpf_pkg::REG_RESET;
            src_base_q  <= bpf_pkg::REG_RESET;
            dest_base_q <= bpf_pkg::REG_RESET;
            extent_q    <= bpf_pkg::REG_RESET;
            config_q    <= bpf_pkg::CFG_RESET;
        end else if (wr_ok) begin
            if (hit_pit)  pitch_q     <= pwdata;
            if (hit_bg)   exp_bg_q    <= pwdata;
            if (hit_fg)   exp_fg_q    <= pwdata;
            if (hit_mono) mono_src_q  <= pwdata;
            if (hit_ctl)  ctrl_q      <= {1'b0, pwdata[30:0]};
            if (hit_pat)  pat_base_q  <= pwdata;
            if (hit_src)  src_base_q  <= pwdata;
            if (hit_dst)  dest_base_q <= pwdata;
            if (hit_ext)  extent_q    <= pwdata;
            if (hit_cfg)  config_q    <= {pwdata[7:1], 1'b0};
        end
    end

    // Busy is set by the launch and cleared in ST_DONE, after the last write or at once for a zero width.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (start) begin
            busy_q <= 1'b1;
        end else if (st_q == bpf_pkg::ST_DONE) begin
            busy_q <= 1'b0;
        end
    end

    // ==========================================================
    // Engine sequencer.
    // ==========================================================
    // Every destination byte is written at 8 bpp; only the depth
    // field is stored, wider depths are not drawn by this engine.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= bpf_pkg::ST_IDLE;
            cnt_q      <= 7'h00;
            x_q        <= 13'h0000;
            y_q        <= 13'h0000;
            line_q     <= 23'h00_0000;
            pat_q      <= 8'h00;
            fb_req_q   <= 1'b0;
            fb_we_q    <= 1'b0;
            fb_addr_q  <= 23'h00_0000;
            fb_wdata_q <= 8'h00;
        end else begin
            unique case (st_q)
                bpf_pkg::ST_IDLE: begin
                    if (start) begin
                        // Registers are final: the height came last.
                        // The first line starts at the destination base.
                        line_q <= dest_base_q[bpf_pkg::DBASE_MSB:0];
                        x_q    <= 13'h0000;
                        y_q    <= 13'h0000;
                        cnt_q  <= 7'h00;
                        st_q   <= bpf_pkg::ST_PREQ;
                    end
                end
                bpf_pkg::ST_PREQ: begin
                    // Skip the fetch when the pattern is not needed.
                    if (width == 13'h0000) begin
                        st_q <= bpf_pkg::ST_DONE;
                    end else if (solid | ~uses_pat) begin
                        st_q <= bpf_pkg::ST_PIX;
                    end else begin
                        fb_req_q  <= 1'b1;
                        fb_we_q   <= 1'b0;
                        fb_addr_q <= pat_addr0 + {16'h0000, cnt_q};
                        st_q      <= bpf_pkg::ST_PWAIT;
                    end
                end
                bpf_pkg::ST_PWAIT: begin
                    if (fb_ack) begin
                        fb_req_q <= 1'b0;
                        cnt_q    <= cnt_q + 7'h01;
                        st_q     <= (cnt_q == pat_last)
                                  ? bpf_pkg::ST_PIX : bpf_pkg::ST_PREQ;
                    end
                end
                bpf_pkg::ST_PIX: begin
                    // Pattern store read address settles here.
                    st_q <= bpf_pkg::ST_CALC;
                end
                bpf_pkg::ST_CALC: begin
                    pat_q <= pat_now;
                    if (skip_pix) begin
                        st_q <= bpf_pkg::ST_DWR;
                    end else begin
                        fb_req_q   <= 1'b1;
                        fb_we_q    <= ~uses_dst;
                        fb_addr_q  <= pix_addr;
                        fb_wdata_q <= rop_res;
                        st_q       <= uses_dst ? bpf_pkg::ST_DRD
                                               : bpf_pkg::ST_DWR;
                    end
                end
                bpf_pkg::ST_DRD: begin
                    // Destination byte is back: turn into the write.
                    if (fb_ack) begin
                        fb_we_q    <= 1'b1;
                        fb_wdata_q <= rop_res;
                        st_q       <= bpf_pkg::ST_DWR;
                    end
                end
                bpf_pkg::ST_DWR: begin
                    // A skipped pixel has no request outstanding.
                    if (fb_ack | ~fb_req_q) begin
                        fb_req_q <= 1'b0;
                        fb_we_q  <= 1'b0;
                        st_q     <= bpf_pkg::ST_PIX;
                        if (!last_x) begin
                            x_q <= x_q + 13'h0001;
                        end else if (!last_y) begin
                            x_q    <= 13'h0000;
                            y_q    <= y_q + 13'h0001;
                            line_q <= line_q + {10'h000, d_pitch};
                        end else begin
                            st_q <= bpf_pkg::ST_DONE;
                        end
                    end
                end
                bpf_pkg::ST_DONE: begin
                    st_q <= bpf_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops.
    // ==========================================================
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign fb_req   = fb_req_q;
    assign fb_we    = fb_we_q;
    assign fb_addr  = fb_addr_q;
    assign fb_wdata = fb_wdata_q;
    assign busy     = busy_q;

endmodule

// file: testbench/bpf_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks for the pattern fill engine.
module bpf_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        fb_req,
    input wire logic        fb_we,
    input wire logic [22:0] fb_addr,
    input wire logic [7:0]  fb_wdata,
    input wire logic        fb_ack,
    input wire logic        busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // An extent write accepted while idle; the height decides a start.
    sequence ext_write;
        psel && penable && pready && pwrite && !busy
            && paddr == bpf_pkg::OFF_EXTENT;
    endsequence
    // A finished read while busy held still, so its value is known.
    sequence rd_done(logic [7:0] a);
        pready && !pwrite && paddr == a && $stable(busy);
    endsequence
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    cfg_busy_a: assert property (
        rd_done(bpf_pkg::OFF_CONFIG) |-> prdata[0] == busy)
        else $error("config busy bit differs from busy");
    ctl_busy_a: assert property (
        rd_done(bpf_pkg::OFF_CONTROL) |-> prdata[31] == busy)
        else $error("control busy bit differs from busy");
    start_busy_a: assert property (
        ext_write ##0 (pwdata[28:16] != 13'h0) |-> ##[1:2] busy)
        else $error("non-zero height did not start");
    zero_height_a: assert property (
        ext_write ##0 (pwdata[28:16] == 13'h0) |-> ##1 !busy [*2])
        else $error("zero height started an operation");
    idle_quiet_a: assert property (!busy |-> !fb_req)
        else $error("memory request while idle");
    req_hold_a: assert property (
        fb_req && !fb_ack |=> fb_req && $stable(fb_addr)
            && $stable(fb_we) && $stable(fb_wdata))
        else $error("memory request changed before its answer");
    start_req_a: assert property (
        $rose(busy) |-> ##[1:8] (fb_req || !busy))
        else $error("started operation made no request");
endmodule

bind bpf_top bpf_checker u_chk (.*);

// file: testbench/bpf_fb_model.sv
`timescale 1ns/1ps
// ==========================================================
// Frame buffer memory: answers after lat idle cycles.
module bpf_fb_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fb_req,
    input  wire logic        fb_we,
    input  wire logic [22:0] fb_addr,
    input  wire logic [7:0]  fb_wdata,
    input  wire logic [1:0]  lat,
    output logic             fb_ack,
    output logic      [7:0]  fb_rdata
);
    logic [7:0] mem [int]; // Bytes the engine has written.
    logic [1:0] wait_q;    // Cycles the current request has waited.
    // One request at a time; read data is a known function of address.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_ack   <= 1'b0;
            fb_rdata <= 8'h00;
            wait_q   <= 2'h0;
        end else if (!fb_ack && fb_req && wait_q >= lat) begin
            fb_ack <= 1'b1;
            wait_q <= 2'h0;
            if (fb_we) mem[int'(fb_addr)] = fb_wdata;
            else fb_rdata <= fb_addr[7:0] ^ 8'h5a;
        end else begin
            // Data churns outside an answer so stale bytes never pass.
            fb_ack   <= 1'b0;
            fb_rdata <= ~fb_rdata;
            if (fb_req && !fb_ack) wait_q <= wait_q + 2'h1;
        end
    end
endmodule

// file: testbench/bpf_top_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Register access and tiled fills checked in frame memory.
module bpf_top_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        fb_req, fb_we, fb_ack, busy, err;
    logic [7:0]  paddr, fb_wdata, fb_rdata;
    logic [22:0] fb_addr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  lat;
    int          miscompares, checks, cyc, a, w, h, r0;
    bpf_top      u_dut (.*);
    bpf_fb_model u_fb (.*);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic complete_run;
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready, then one idle cycle.
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Software waits for idle before touching the engine.
    task automatic poll;
        do apb(1'b0, bpf_pkg::OFF_CONFIG, 32'h0); while (rd[0] !== 1'b0);
    endtask
    // Colour tile byte, or a one-bit row expanded: zero is foreground.
    function automatic logic [7:0] pat(int x, int y, int r, int m);
        logic [7:0] b;
        b = 8'(m ? (r + y) % 8 : ((r + y) % 8) * 8 + x % 8) ^ 8'h5a;
        return (m == 0) ? b : (b[7 - x % 8] ? 8'h00 : 8'hc3);
    endfunction
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 30000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, lat} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, (i == 9) ? 8'h80 : 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, bpf_pkg::OFF_EXTENT, 32'h0000_0005);
        poll();
        apb(1'b0, bpf_pkg::OFF_EXTENT, 32'h0);
        chk(rd, 32'h0000_0005);
        for (int t = 0; t < 3; t++) begin
            w = 8 + t;
            h = 8 + 2 * t;
            r0 = 5 * t;
            lat <= 2'(2 * t);
            u_fb.mem.delete();
            poll();
            apb(1'b1, bpf_pkg::OFF_CONFIG, 32'h0);
            apb(1'b1, bpf_pkg::OFF_DEST_PITCH, 32'h0010_0003);
            apb(1'b1, bpf_pkg::OFF_PAT_BASE, 32'h0010_0005);
            apb(1'b1, bpf_pkg::OFF_DEST_BASE, 32'h0000_2008);
            apb(1'b1, bpf_pkg::OFF_EXP_FG, 32'hc3);
            apb(1'b1, bpf_pkg::OFF_CONTROL, {9'h0, r0[2:0], 1'b0,
                1'(t == 2), 10'h0, (t == 2) ? 8'hfa : 8'hf0});
            apb(1'b1, bpf_pkg::OFF_EXTENT, {3'h0, 13'(h), 3'h0, 13'(w)});
            apb(1'b0, bpf_pkg::OFF_CONTROL, 32'h0);
            chk({31'h0, rd[31]}, 32'h1);
            poll();
            for (int y = 0; y <= h; y++) for (int x = 0; x <= w; x++) begin
                a = 32'h2008 + y * 16 + x;
                if (u_fb.mem.exists(a)) chk({24'h0, u_fb.mem[a]},
                    (x < w && y < h) ? {24'h0, pat(x, y, r0, t == 2)
                    | (t == 2 ? 8'(a) ^ 8'h5a : 8'h00)} : '1);
                else chk(32'h0, 32'((x < w && y < h)));
            end
        end
        complete_run();
    end
endmodule
